//--- hw/sanse_pkg.sv
package sanse_pkg;
   // widths of the instruction word, data byte and file address
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   // field positions inside the instruction word
   localparam int OPC_MSB = 13;
   localparam int OPC_LSB = 8;
   localparam int DEST_POS = 7;
   localparam int ADDR_MSB = 6;
   localparam int ADDR_LSB = 0;
   // nibble positions inside a data byte
   localparam int NIB_HI_MSB = 7;
   localparam int NIB_HI_LSB = 4;
   localparam int NIB_LO_MSB = 3;
   localparam int NIB_LO_LSB = 0;
   // opcode fields of the two instructions handled here
   localparam logic [5:0] OPC_SUBTRACT_WORK_FROM_FILE = 6'h02;
   localparam logic [5:0] OPC_SWAP_FILE_NIBBLES = 6'h0E;
   // destination bit values
   localparam logic DEST_WORK = 1'h0;
   localparam logic DEST_FILE = 1'h1;
   // values after reset
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic FLAG_RST = 1'h0;
   // cycles from an accepted instruction to its registered result
   localparam int EXEC_CYCLES = 1;

   // operation chosen by the decoder stage of this block
   typedef enum logic [1:0] {
      SANSE_OP_NONE,
      SANSE_OP_SUB,
      SANSE_OP_SWAP
   } sanse_op_type;
endpackage

//--- hw/sanse_alu.sv
`timescale 1ns/1ps
// combinational arithmetic for both instructions
module sanse_alu (
   input wire logic sub_sel,
   input wire logic [7:0] file_val,
   input wire logic [7:0] work_val,
   output logic [7:0] result,
   output logic carry,
   output logic digit_carry_flag,
   output logic zero
);
   // true when minuend >= subtrahend, i.e. no borrow leaves the field
   function automatic logic no_borrow(input logic [7:0] a, input logic [7:0] b);
      begin
         no_borrow = (a >= b);
      end
   endfunction

   // difference wraps modulo 256, which is two's complement subtraction
   logic [7:0] diff;
   // nibble-exchanged copy of the source byte
   logic [7:0] swapped;

   // compute both results and pick one; flags only matter for subtract
   always_comb begin
      diff = file_val - work_val;
      swapped = {file_val[sanse_pkg::NIB_LO_MSB:sanse_pkg::NIB_LO_LSB],
                 file_val[sanse_pkg::NIB_HI_MSB:sanse_pkg::NIB_HI_LSB]};
      result = sub_sel ? diff : swapped;
      carry = no_borrow(file_val, work_val);
      digit_carry_flag = no_borrow({4'h0, file_val[3:0]}, {4'h0, work_val[3:0]});
      zero = (diff == 8'h00);
   end
endmodule

//--- hw/sanse_exec.sv
`timescale 1ns/1ps
// What this block does
// - opcode 000010 subtracts working from file
// - destination 0: difference into working register
// - destination 1: difference back to file
// - no borrow sets carry
// - borrow clears carry, result wraps
// - opcode 001110 swaps nibbles, flags untouched
// - destination 0: swapped byte into working
// - destination 1: swapped byte back to file
module sanse_exec (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic exec_valid,
   input wire logic [13:0] exec_instr,
   input wire logic [7:0] file_rd_data,
   input wire logic work_load_en,
   input wire logic [7:0] work_load_data,
   output logic [7:0] work_q,
   output logic file_we_q,
   output logic [6:0] file_addr_q,
   output logic [7:0] file_wdata_q,
   output logic carry_q,
   output logic digit_carry_flag_q,
   output logic zero_q,
   output logic done_q,
   output logic unsupported_q
);
   // decoded operation of the offered instruction
   sanse_pkg::sanse_op_type op;
   // destination bit and file address taken from the word
   logic dest;
   logic [6:0] addr;
   // source byte after forwarding
   logic [7:0] operand;
   // alu results
   logic [7:0] alu_result;
   logic alu_carry;
   logic alu_dc;
   logic alu_zero;
   // next values of all registers
   logic [7:0] work_d;
   logic file_we_d;
   logic [6:0] file_addr_d;
   logic [7:0] file_wdata_d;
   logic carry_d;
   logic digit_carry_flag_d;
   logic zero_d;
   logic done_d;
   logic unsupported_d;

   // map the opcode field onto an operation
   function automatic sanse_pkg::sanse_op_type decode(input logic [5:0] opc);
      begin
         if (opc == sanse_pkg::OPC_SUBTRACT_WORK_FROM_FILE) begin
            decode = sanse_pkg::SANSE_OP_SUB;
         end else if (opc == sanse_pkg::OPC_SWAP_FILE_NIBBLES) begin
            decode = sanse_pkg::SANSE_OP_SWAP;
         end else begin
            decode = sanse_pkg::SANSE_OP_NONE;
         end
      end
   endfunction

   // field split and operand forwarding
   always_comb begin
      op = exec_valid ? decode(exec_instr[sanse_pkg::OPC_MSB:sanse_pkg::OPC_LSB])
                      : sanse_pkg::SANSE_OP_NONE;
      dest = exec_instr[sanse_pkg::DEST_POS];
      addr = exec_instr[sanse_pkg::ADDR_MSB:sanse_pkg::ADDR_LSB];
      // the file write lands one edge late, so a back-to-back read of the
      // same address would see the stale byte; forward the pending value
      if (file_we_q && (file_addr_q == addr)) begin
         operand = file_wdata_q;
      end else begin
         operand = file_rd_data;
      end
   end

   sanse_alu u_alu (
      .sub_sel(op == sanse_pkg::SANSE_OP_SUB),
      .file_val(operand),
      .work_val(work_q),
      .result(alu_result),
      .carry(alu_carry),
      .digit_carry_flag(alu_dc),
      .zero(alu_zero)
   );

   // next-state logic for working register, file write port and flags
   always_comb begin
      work_d = work_q;
      file_we_d = 1'h0;
      file_addr_d = file_addr_q;
      file_wdata_d = file_wdata_q;
      carry_d = carry_q;
      digit_carry_flag_d = digit_carry_flag_q;
      zero_d = zero_q;
      done_d = 1'h0;
      unsupported_d = 1'h0;
      // a separate load from the decoder; an executing instruction wins
      if (work_load_en) begin
         work_d = work_load_data;
      end
      unique case (op)
         sanse_pkg::SANSE_OP_SUB: begin
            carry_d = alu_carry;
            digit_carry_flag_d = alu_dc;
            zero_d = alu_zero;
            done_d = 1'h1;
            if (dest == sanse_pkg::DEST_WORK) begin
               work_d = alu_result;
            end else begin
               work_d = work_q;
               file_we_d = 1'h1;
               file_addr_d = addr;
               file_wdata_d = alu_result;
            end
         end
         sanse_pkg::SANSE_OP_SWAP: begin
            // flags keep their values: nibble swap affects no status
            done_d = 1'h1;
            if (dest == sanse_pkg::DEST_WORK) begin
               work_d = alu_result;
            end else begin
               work_d = work_q;
               file_we_d = 1'h1;
               file_addr_d = addr;
               file_wdata_d = alu_result;
            end
         end
         sanse_pkg::SANSE_OP_NONE: begin
            // other opcodes belong to other units; flag them once
            unsupported_d = exec_valid;
         end
      endcase
   end

   // registers only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         work_q <= sanse_pkg::WORK_RST;
         file_we_q <= sanse_pkg::FLAG_RST;
         file_addr_q <= sanse_pkg::ADDR_RST;
         file_wdata_q <= sanse_pkg::WORK_RST;
         carry_q <= sanse_pkg::FLAG_RST;
         digit_carry_flag_q <= sanse_pkg::FLAG_RST;
         zero_q <= sanse_pkg::FLAG_RST;
         done_q <= sanse_pkg::FLAG_RST;
         unsupported_q <= sanse_pkg::FLAG_RST;
      end else begin
         work_q <= work_d;
         file_we_q <= file_we_d;
         file_addr_q <= file_addr_d;
         file_wdata_q <= file_wdata_d;
         carry_q <= carry_d;
         digit_carry_flag_q <= digit_carry_flag_d;
         zero_q <= zero_d;
         done_q <= done_d;
         unsupported_q <= unsupported_d;
      end
   end

   // checks on the registered results
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // instruction issue forms
   sequence s_sub_issue;
      op == sanse_pkg::SANSE_OP_SUB;
   endsequence
   sequence s_swap_issue;
      op == sanse_pkg::SANSE_OP_SWAP;
   endsequence
   sequence s_to_work;
      dest == sanse_pkg::DEST_WORK;
   endsequence
   sequence s_to_file;
      dest == sanse_pkg::DEST_FILE;
   endsequence

   property p_sub_value;
      s_sub_issue and s_to_work |=>
         work_q == 8'($past(operand) - $past(work_q));
   endproperty
   a_sub_value: assert property (p_sub_value) else $error("subtract gave wrong difference");

   property p_sub_to_work;
      s_sub_issue and s_to_work |=> !file_we_q && done_q;
   endproperty
   a_sub_to_work: assert property (p_sub_to_work) else $error("subtract to work wrote file");

   property p_sub_to_file;
      s_sub_issue and s_to_file |=> file_we_q && work_q == $past(work_q)
         && file_addr_q == $past(addr)
         && file_wdata_q == 8'($past(operand) - $past(work_q));
   endproperty
   a_sub_to_file: assert property (p_sub_to_file) else $error("subtract to file wrong");

   property p_carry_set;
      s_sub_issue ##0 (operand >= work_q) |=> carry_q;
   endproperty
   a_carry_set: assert property (p_carry_set) else $error("carry not set without borrow");

   property p_carry_clr;
      s_sub_issue ##0 (operand < work_q) |=> !carry_q;
   endproperty
   a_carry_clr: assert property (p_carry_clr) else $error("carry not cleared on borrow");

   property p_swap_flags;
      s_swap_issue |=> $stable(carry_q) && $stable(digit_carry_flag_q) && $stable(zero_q);
   endproperty
   a_swap_flags: assert property (p_swap_flags) else $error("swap changed a flag");

   property p_swap_to_work;
      s_swap_issue and s_to_work |=> !file_we_q
         && work_q == {$past(operand[3:0]), $past(operand[7:4])};
   endproperty
   a_swap_to_work: assert property (p_swap_to_work) else $error("swap to work wrong");

   property p_swap_to_file;
      s_swap_issue and s_to_file |=> file_we_q && work_q == $past(work_q)
         && file_addr_q == $past(addr)
         && file_wdata_q == {$past(operand[3:0]), $past(operand[7:4])};
   endproperty
   a_swap_to_file: assert property (p_swap_to_file) else $error("swap to file wrong");

   property p_one_cycle;
      (s_sub_issue or s_swap_issue) ##1 (op == sanse_pkg::SANSE_OP_NONE) |=> !done_q;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("done longer than one cycle");

   property p_done_at_once;
      (s_sub_issue or s_swap_issue) |=> done_q;
   endproperty
   a_done_at_once: assert property (p_done_at_once) else $error("result late");

   property p_zero_dc;
      s_sub_issue |=> zero_q == ($past(operand) == $past(work_q))
         && digit_carry_flag_q == ($past(operand[3:0]) >= $past(work_q[3:0]));
   endproperty
   a_zero_dc: assert property (p_zero_dc) else $error("zero or digit carry wrong");
endmodule

//--- tb/sanse_file_model.sv
`timescale 1ns/1ps
// behavioural data register file that faces the execution block
module sanse_file_model (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic rd_valid,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic wr_en,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] mem_q [128]; // 128 bytes, full 7-bit address range

   // read is combinational; unselected cycles show inverted data so stale values never pass
   always_comb begin
      if (rd_valid) begin
         rd_data = mem_q[rd_addr];
      end else begin
         rd_data = ~mem_q[rd_addr];
      end
   end

   // a write lands at the edge after the strobe, so the very next read may be stale
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 128; i++) mem_q[i] <= 8'h00;
      end else if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end
endmodule

//--- tb/tb_subtract_and_nibble_swap_exec.sv
`timescale 1ns/1ps
// self-checking bench for the subtract and nibble swap datapath
module tb_subtract_and_nibble_swap_exec;
   localparam logic [5:0] SUB = sanse_pkg::OPC_SUBTRACT_WORK_FROM_FILE;
   localparam logic [5:0] SWP = sanse_pkg::OPC_SWAP_FILE_NIBBLES;
   logic sys_clk = 1'h0, rst_b = 1'h0, exec_valid = 1'h0, work_load_en = 1'h0;
   logic [13:0] exec_instr = 14'h0000;
   logic [7:0] file_rd_data, work_load_data = 8'h00, work_q, file_wdata_q;
   logic [6:0] file_addr_q;
   logic file_we_q, carry_q, digit_carry_flag_q, zero_q, done_q, unsupported_q;
   logic [7:0] mem_s [128]; // shadow of the file contents
   logic [7:0] work_s;
   logic c_s, dc_s, z_s;
   int err_count = 0, check_count = 0;

   sanse_exec dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .exec_valid(exec_valid),
      .exec_instr(exec_instr), .file_rd_data(file_rd_data), .work_load_en(work_load_en),
      .work_load_data(work_load_data), .work_q(work_q), .file_we_q(file_we_q),
      .file_addr_q(file_addr_q), .file_wdata_q(file_wdata_q), .carry_q(carry_q),
      .digit_carry_flag_q(digit_carry_flag_q), .zero_q(zero_q), .done_q(done_q),
      .unsupported_q(unsupported_q));
   sanse_file_model part_u (.sys_clk(sys_clk), .rst_b(rst_b), .rd_valid(exec_valid),
      .rd_addr(exec_instr[6:0]), .rd_data(file_rd_data), .wr_en(file_we_q),
      .wr_addr(file_addr_q), .wr_data(file_wdata_q));

   // 250 MHz clock
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // reset shadows too; the partner clears its file on the same reset
   task automatic do_reset(input int cyc);
      rst_b = 1'h0;
      exec_valid = 1'h0;
      work_load_en = 1'h0;
      repeat (cyc) @(negedge sys_clk);
      for (int i = 0; i < 128; i++) mem_s[i] = 8'h00;
      {work_s, c_s, dc_s, z_s} = 11'h000;
      // work register alone, so no bit of it is cut off by the 8-bit compare
      chk(work_q, 8'h00);
      chk({5'h00, carry_q, digit_carry_flag_q, zero_q}, 8'h00);
      chk({file_we_q, file_addr_q}, 8'h00);
      chk(file_wdata_q, 8'h00);
      chk({6'h00, done_q, unsupported_q}, 8'h00);
      rst_b = 1'h1;
   endtask

   // expected byte of either instruction, worked out from the rules alone
   function automatic logic [7:0] exp_result(input logic [5:0] op, input logic [7:0] f,
      input logic [7:0] w);
      exp_result = (op == SWP) ? {f[3:0], f[7:4]} : 8'(f - w);
   endfunction

   // drive one cycle at the falling edge, check the registered answer one cycle later
   task automatic step(input logic v, input logic [5:0] op, input logic d,
      input logic [6:0] a, input logic le, input logic [7:0] ld);
      logic [7:0] f, r;
      logic isx;
      f = mem_s[a];
      isx = v && (op == SUB || op == SWP);
      r = exp_result(op, f, work_s);
      exec_valid = v;
      exec_instr = {op, d, a};
      work_load_en = le;
      work_load_data = ld;
      if (isx) begin
         if (op == SUB) begin
            c_s = f >= work_s;
            dc_s = f[3:0] >= work_s[3:0];
            z_s = r == 8'h00;
         end
         if (d) mem_s[a] = r;
         else work_s = r;
      end else if (le) begin
         work_s = ld;
      end
      @(negedge sys_clk);
      chk(work_q, work_s);
      chk({carry_q, digit_carry_flag_q, zero_q}, {c_s, dc_s, z_s});
      chk({done_q, unsupported_q}, {isx, v && !isx});
      chk(file_we_q, isx && d);
      if (isx && d) begin
         chk({1'h0, file_addr_q}, {1'h0, a});
         chk(file_wdata_q, r);
      end
   endtask

   // put value v into file a through the datapath itself
   task automatic set_file(input logic [6:0] a, input logic [7:0] v);
      // work = old file - v, so old file - work leaves exactly v behind
      step(1'h0, 6'h00, 1'h0, a, 1'h1, mem_s[a] - v);
      step(1'h1, SUB, 1'h1, a, 1'h0, 8'h00);
   endtask

   // watchdog sized well above the planned run length
   initial begin
      #(4 * 20000);
      err_count++;
      report_and_stop();
   end

   initial begin
      void'($urandom(32'h6C36931F));
      do_reset(6);
      // worked subtractions: positive, zero and wrapping results into the file
      for (int k = 1; k <= 3; k++) begin
         set_file(7'h10, 8'(k));
         step(1'h0, 6'h00, 1'h0, 7'h10, 1'h1, 8'h02);
         step(1'h1, SUB, 1'h1, 7'h10, 1'h0, 8'h00);
      end
      // swap into work, then back into the file at the top address, back to back
      set_file(7'h7F, 8'hA5);
      step(1'h1, SWP, 1'h0, 7'h7F, 1'h0, 8'h00);
      step(1'h1, SWP, 1'h1, 7'h7F, 1'h0, 8'h00);
      step(1'h1, SWP, 1'h1, 7'h7F, 1'h0, 8'h00);
      // instruction wins over a work load in the same cycle; other opcode only pulses
      step(1'h1, SUB, 1'h0, 7'h7F, 1'h1, 8'h3C);
      step(1'h1, 6'h07, 1'h1, 7'h7F, 1'h0, 8'h00);
      $display("directed tests done");
      for (int n = 0; n < 600; n++) begin
         logic [5:0] op;
         logic [6:0] a;
         op = ($urandom % 3 == 0) ? SWP : ($urandom % 5 == 0) ? 6'($urandom) : SUB;
         a = ($urandom % 8 == 0) ? 7'h7F : 7'($urandom % 4);
         step(1'($urandom % 6 != 0), op, 1'($urandom), a, 1'($urandom), 8'($urandom));
         if (n == 300) begin
            do_reset(2);
         end
      end
      step(1'h0, 6'h00, 1'h0, 7'h00, 1'h0, 8'h00);
      $display("random tests done");
      report_and_stop();
   end
endmodule
